//--- pkg/urbs_pkg.sv
// Constants and types of the receive buffer and status block
package urbs_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_FORMAT = 4'h8;
   localparam logic [3:0] ADDR_DATA = 4'hC;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ST_PENDING = 7;
   localparam int ST_STOP_ERR = 4;
   localparam int ST_OVERRUN = 3;
   localparam int ST_PARITY_ERR = 2;
   localparam int CT_IRQ_EN = 7;
   localparam int CT_RX_EN = 4;
   localparam int CT_NINTH = 1;
   localparam int FM_PAR_EN = 5;
   localparam int FM_PAR_ODD = 4;
   localparam int FM_STOP_CNT = 3;
   localparam int FM_SIZE_LSB = 0;
   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] FORMAT_RST = 8'h06;
   localparam logic [2:0] SIZE_NINE = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int FIFO_DEPTH = 2;

   // One buffered character with its frame flags
   typedef struct packed {
      logic [8:0] data;
      logic stop_err;
      logic overrun;
      logic parity_err;
   } urbs_entry_t;

   // Frame handed over by the bit recovery front end
   typedef struct packed {
      logic [8:0] bits;
      logic parity;
      logic stop;
   } urbs_frame_t;
endpackage

//--- core/urbs_rx.sv
// Receive buffer, error flags and AXI4-Lite registers of the serial receiver
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Function
// RL1: pending flag high while buffer holds characters
// RL2: receiver disable empties the buffer
// RL3: interrupt requested while pending and enabled
// RL4: error flags travel with their character
// RL5: software reads status before data
// RL6: writes to error flag positions ignored
// RL7: error flags never raise interrupts
// RL8: stop error from first stop bit
// RL9: overrun on full buffer, waiting char, start
// RL10: overrun visible after earlier characters read
// RL11: overrun cleared on successful transfer
// RL12: parity checked when enabled, odd or even
// RL13: parity flag only if checked at arrival
// RL14: parity flag reads zero when disabled
// RL15: disable is immediate, pin released
// RL16: software flushes by reading data repeatedly
// RL17: ninth bit buffered, read before data
// RL18: short characters read zero-padded
// RL19: transfer after first stop bit
// RL20: interrupt is pending AND enable, level
module urbs_rx #(
   parameter int DEPTH = urbs_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [3:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rx_start,
   input wire logic rx_done,
   input wire urbs_pkg::urbs_frame_t rx_frame,
   output logic rxd_owned,
   output logic rx_irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   urbs_pkg::urbs_entry_t mem_q [DEPTH];
   logic rd_ptr_q, wr_ptr_q;
   logic [1:0] cnt_q, cnt_d;
   urbs_pkg::urbs_entry_t hold_q;
   logic hold_v_q, hold_v_d;
   logic ovr_pend_q, ovr_pend_d;
   logic [7:0] control_q, format_q;
   logic aw_v_q, w_v_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   // ----------------------------------------
   // Decoding
   // ----------------------------------------
   wire rx_en = control_q[urbs_pkg::CT_RX_EN];
   wire irq_en = control_q[urbs_pkg::CT_IRQ_EN];
   wire par_en = format_q[urbs_pkg::FM_PAR_EN];
   wire par_odd = format_q[urbs_pkg::FM_PAR_ODD];
   wire [2:0] size = format_q[urbs_pkg::FM_SIZE_LSB +: 3];
   wire pending = (cnt_q != 2'h0);
   wire full = (cnt_q == 2'(DEPTH));
   wire urbs_pkg::urbs_entry_t head = mem_q[rd_ptr_q];
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire pop = ar_take && (s_axi_araddr == urbs_pkg::ADDR_DATA) && pending;
   wire do_write = aw_v_q && w_v_q && !s_axi_bvalid;
   wire wr_ctl = do_write && (aw_addr_q == urbs_pkg::ADDR_CONTROL)
      && w_strb_q[0];
   wire wr_fmt = do_write && (aw_addr_q == urbs_pkg::ADDR_FORMAT)
      && w_strb_q[0];
   wire wr_ok = (aw_addr_q[3:2] != 2'h3);

   // Mask of data bits in use for the selected character size
   function automatic logic [8:0] size_mask(input logic [2:0] sz);
      unique case (sz)
         3'h0: size_mask = 9'h01F;
         3'h1: size_mask = 9'h03F;
         3'h2: size_mask = 9'h07F;
         3'h7: size_mask = 9'h1FF;
         default: size_mask = 9'h0FF;
      endcase
   endfunction

   // ----------------------------------------
   // Frame capture into the shift stage
   // ----------------------------------------
   // RL18: unused high bits stored as zero
   wire [8:0] rx_data = rx_frame.bits & size_mask(size);
   // RL12: computed parity against the received bit
   wire par_calc = (^rx_data) ^ par_odd;
   wire urbs_pkg::urbs_entry_t rx_entry = '{
      data: rx_data,
      // RL8: first stop bit only, stop count ignored
      stop_err: !rx_frame.stop,
      overrun: 1'b0,
      // RL13: flag only when checking was on at arrival
      parity_err: par_en && (par_calc != rx_frame.parity)
   };
   // RL9: full buffer, waiting character and a new start
   wire overrun = rx_en && rx_start && full && hold_v_q && !pop;
   wire room = !full || pop;
   wire push = rx_en && hold_v_q && room;

   always_comb begin
      hold_v_d = hold_v_q;
      ovr_pend_d = ovr_pend_q;
      cnt_d = cnt_q;
      if (!rx_en) begin
         // RL2: disable flushes buffer and pending overrun
         hold_v_d = 1'b0;
         ovr_pend_d = 1'b0;
         cnt_d = 2'h0;
      end else begin
         if (push) begin
            hold_v_d = 1'b0;
         end
         // RL9: the waiting character is lost
         if (overrun) begin
            hold_v_d = 1'b0;
            ovr_pend_d = 1'b1;
         end
         // RL11: a successful transfer ends the overrun
         if (push) begin
            ovr_pend_d = 1'b0;
         end
         // RL19: frame taken once first stop bit is in
         if (rx_done) begin
            hold_v_d = 1'b1;
         end
         cnt_d = cnt_q + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hold_v_q <= 1'b0;
         ovr_pend_q <= 1'b0;
         cnt_q <= 2'h0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
      end else begin
         hold_v_q <= hold_v_d;
         ovr_pend_q <= ovr_pend_d;
         cnt_q <= cnt_d;
         if (!rx_en) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
         end else begin
            rd_ptr_q <= rd_ptr_q ^ pop;
            wr_ptr_q <= wr_ptr_q ^ push;
         end
      end
   end

   // RL4: flags stored beside their character
   // RL10: overrun tag rides on the next stored character
   always_ff @(posedge clk) begin
      if (rx_done) begin
         hold_q <= rx_entry;
      end
      if (push) begin
         mem_q[wr_ptr_q] <= '{
            data: hold_q.data,
            stop_err: hold_q.stop_err,
            overrun: ovr_pend_q,
            parity_err: hold_q.parity_err};
      end
   end

   // ----------------------------------------
   // Register write path
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_v_q <= 1'b0;
         w_v_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= urbs_pkg::RESP_OKAY;
         control_q <= urbs_pkg::CONTROL_RST;
         format_q <= urbs_pkg::FORMAT_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_v_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_v_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_v_q <= 1'b0;
            w_v_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? urbs_pkg::RESP_OKAY
               : urbs_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // RL15: clearing the enable acts on the next edge
         if (wr_ctl) begin
            control_q <= w_data_q[7:0];
         end
         if (wr_fmt) begin
            format_q <= w_data_q[7:0];
         end
         // RL6: status holds no writable bits
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_v_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_v_q && !(s_axi_wvalid && s_axi_wready);
      end
   end

   // ----------------------------------------
   // Register read path
   // ----------------------------------------
   logic [7:0] status_rd;
   always_comb begin
      status_rd = 8'h00;
      // RL1: pending whenever unread characters exist
      status_rd[urbs_pkg::ST_PENDING] = pending;
      status_rd[urbs_pkg::ST_STOP_ERR] = pending && head.stop_err;
      status_rd[urbs_pkg::ST_OVERRUN] = pending && head.overrun;
      // RL14: parity flag masked while checking is off
      status_rd[urbs_pkg::ST_PARITY_ERR] = pending && par_en
         && head.parity_err;
   end
   wire [7:0] control_rd = {control_q[7:2],
      pending && head.data[8], control_q[0]};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (s_axi_araddr[3:2])
         2'h0: rd_mux = {24'h00_0000, status_rd};
         // RL17: ninth bit follows the read position
         2'h1: rd_mux = {24'h00_0000, control_rd};
         2'h2: rd_mux = {24'h00_0000, format_q};
         2'h3: rd_mux = {24'h00_0000, pending ? head.data[7:0] : 8'h00};
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= urbs_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            // RL5: a data read moves the read position
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= urbs_pkg::RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pin ownership and interrupt
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         rxd_owned <= 1'b0;
         rx_irq <= 1'b0;
      end else begin
         // RL15: pin released as soon as the enable drops
         rxd_owned <= (wr_ctl ? w_data_q[urbs_pkg::CT_RX_EN] : rx_en);
         // RL3: level request while pending and enabled
         // RL20: AND of pending and enable
         // RL7: error flags take no part here
         rx_irq <= (cnt_d != 2'h0) && (wr_ctl
            ? w_data_q[urbs_pkg::CT_IRQ_EN] : irq_en);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_irq_level: assert property (@(posedge clk) disable iff (srst)
      rx_irq == (pending && irq_en)) // RL20
      else $error("irq differs from pending and enable");
   a_irq_hold: assert property (@(posedge clk) disable iff (srst)
      pending && irq_en && !pop && !wr_ctl |=> rx_irq) // RL3
      else $error("irq dropped while pending");
   a_flush_off: assert property (@(posedge clk) disable iff (srst)
      !rx_en |=> cnt_q == 2'h0 && !hold_v_q) // RL2
      else $error("buffer not flushed on disable");
   a_pend_empty: assert property (@(posedge clk) disable iff (srst)
      push |=> status_rd[urbs_pkg::ST_PENDING]) // RL1
      else $error("pending flag wrong");
   a_par_off: assert property (@(posedge clk) disable iff (srst)
      !par_en |-> !status_rd[urbs_pkg::ST_PARITY_ERR]) // RL14
      else $error("parity flag set while checking off");
   a_ovr_mark: assert property (@(posedge clk) disable iff (srst)
      overrun |=> ovr_pend_q && !hold_v_q) // RL9
      else $error("overrun not recorded");
   a_ovr_clear: assert property (@(posedge clk) disable iff (srst)
      push && !overrun |=> !ovr_pend_q) // RL11
      else $error("overrun not cleared on transfer");
   a_pop_move: assert property (@(posedge clk) disable iff (srst)
      pop && !push |=> cnt_q == $past(cnt_q) - 2'h1) // RL5
      else $error("data read did not advance buffer");
   a_pin_owned: assert property (@(posedge clk) disable iff (srst)
      $fell(rx_en) |-> !rxd_owned) // RL15
      else $error("pin kept after disable");
endmodule

//--- dv/urbs_tx_model.sv
// Remote serial transmitter as seen after bit recovery
`timescale 1ns/100ps
module urbs_tx_model (
   input wire logic clk,
   output logic rx_start,
   output logic rx_done,
   output urbs_pkg::urbs_frame_t rx_frame
);
   initial begin
      rx_start = 1'b0;
      rx_done = 1'b0;
      rx_frame = '0;
   end

   // Start pulse, then the whole frame unless fin is low
   task automatic send(input logic [8:0] b, input logic p, input logic s,
                       input logic fin);
      @(posedge clk);
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      if (fin) begin
         repeat (4) @(posedge clk);
         rx_done <= 1'b1;
         rx_frame <= urbs_pkg::urbs_frame_t'({b, p, s});
         @(posedge clk);
         rx_done <= 1'b0;
         // Stale frame inverted so it is never mistaken for valid
         rx_frame <= urbs_pkg::urbs_frame_t'(~{b, p, s});
         repeat (3) @(posedge clk);
      end
   endtask
endmodule

//--- dv/urbs_rx_tb_top.sv
// Self-checking bench of the receive buffer and status block
`timescale 1ns/100ps
module urbs_rx_tb_top;
   localparam logic [3:0] A_ST = urbs_pkg::ADDR_STATUS;
   localparam logic [3:0] A_CT = urbs_pkg::ADDR_CONTROL;
   localparam logic [3:0] A_FM = urbs_pkg::ADDR_FORMAT;
   localparam logic [3:0] A_DT = urbs_pkg::ADDR_DATA;
   logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, rx_start, rx_done, rxd_owned, rx_irq;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   urbs_pkg::urbs_frame_t rx_frame;
   int n_errors, checks_done;

   urbs_rx dut_u (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .rx_start, .rx_done, .rx_frame, .rxd_owned, .rx_irq);
   urbs_tx_model tx_u (.clk, .rx_start, .rx_done, .rx_frame);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask

   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (n == 40) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      int n;
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      if (n == 40) begin
         n_errors++;
         report_and_stop();
      end
      chk(v, e);
      chk(s_axi_rresp, urbs_pkg::RESP_OKAY);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_basic;
      wr(A_FM, 8'h06);
      wr(A_CT, 8'h90);
      chk(r, urbs_pkg::RESP_OKAY);
      rc(A_ST, 32'h0); // empty
      tx_u.send(9'h0A5, 1'b0, 1'b1, 1'b1);
      rc(A_ST, 32'h80); // pending set
      chk(rx_irq, 1'b1); // level request
      chk(rxd_owned, 1'b1); // pin owned
      rc(A_DT, 32'hA5); // char moved
      repeat (3) @(posedge clk);
      chk(rx_irq, 1'b0); // request drops
   endtask

   task automatic t_errors;
      wr(A_CT, 8'h10);
      wr(A_FM, 8'h26);
      tx_u.send(9'h003, 1'b1, 1'b0, 1'b1);
      rc(A_ST, 32'h94); // status read first
      chk(rx_irq, 1'b0); // no error request
      // Zeros written to flags that are set must not clear them
      wr(A_ST, 8'h00); // software writes zeros
      chk(r, urbs_pkg::RESP_OKAY); // write ignored
      wr(A_DT, 8'h00); // data write is no pop
      chk(r, urbs_pkg::RESP_SLVERR); // data write refused
      rc(A_ST, 32'h94); // flags kept
      rc(A_DT, 32'h03); // valid until read
      wr(A_FM, 8'h3E);
      tx_u.send(9'h003, 1'b1, 1'b1, 1'b1);
      rc(A_ST, 32'h80); // odd parity matches
      rc(A_DT, 32'h03); // data intact
      tx_u.send(9'h003, 1'b0, 1'b1, 1'b1);
      wr(A_FM, 8'h06);
      rc(A_ST, 32'h80); // stored mismatch masked
      rc(A_DT, 32'h03); // data intact
      tx_u.send(9'h003, 1'b0, 1'b1, 1'b1);
      wr(A_FM, 8'h26);
      rc(A_ST, 32'h80); // unchecked at arrival
      rc(A_DT, 32'h03); // data intact
      wr(A_FM, 8'h06);
   endtask

   task automatic t_overrun;
      tx_u.send(9'h011, 1'b0, 1'b1, 1'b1);
      tx_u.send(9'h022, 1'b0, 1'b1, 1'b1);
      tx_u.send(9'h033, 1'b0, 1'b1, 1'b1);
      tx_u.send(9'h000, 1'b0, 1'b1, 1'b0);
      rc(A_ST, 32'h80); // hidden behind head
      rc(A_DT, 32'h11); // order kept
      rc(A_ST, 32'h80); // still hidden
      rc(A_DT, 32'h22); // waiting char lost
      tx_u.send(9'h044, 1'b0, 1'b1, 1'b1);
      rc(A_ST, 32'h88); // overrun shown
      rc(A_DT, 32'h44); // third char gone
      tx_u.send(9'h055, 1'b0, 1'b1, 1'b1);
      rc(A_ST, 32'h80); // overrun cleared
      rc(A_DT, 32'h55); // flush by reading
      rc(A_ST, 32'h00); // empty again
   endtask

   task automatic t_sizes;
      wr(A_FM, 8'h07);
      tx_u.send(9'h1C3, 1'b0, 1'b1, 1'b1);
      rc(A_CT, 32'h12); // ninth bit first
      rc(A_DT, 32'hC3); // low bits after
      wr(A_FM, 8'h00);
      tx_u.send(9'h1FF, 1'b0, 1'b1, 1'b1);
      rc(A_DT, 32'h1F); // upper bits zero
   endtask

   task automatic t_disable;
      wr(A_FM, 8'h06);
      tx_u.send(9'h066, 1'b0, 1'b1, 1'b1);
      tx_u.send(9'h077, 1'b0, 1'b1, 1'b1);
      wr(A_CT, 8'h00);
      rc(A_ST, 32'h00); // buffer flushed
      chk(rxd_owned, 1'b0); // pin released
      tx_u.send(9'h088, 1'b0, 1'b1, 1'b1);
      wr(A_CT, 8'h10);
      rc(A_ST, 32'h00); // frame while off lost
      rc(A_DT, 32'h00); // nothing kept
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      srst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'h1;
      s_axi_wdata = 32'h0;
      n_errors = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      rc(A_CT, 32'h00);
      rc(A_FM, 32'h06);
      t_basic();
      t_errors();
      t_overrun();
      t_sizes();
      t_disable();
      report_and_stop();
   end
endmodule
